//--- css_skip_seq.sv
`timescale 1ns/1ps
module css_skip_seq
  import css_pkg::*;
#(
  parameter int unsigned PC_W  = 16,
  parameter int unsigned ACC_W = 24
) (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         clk_en,
  input  wire logic                         skip_valid,
  input  wire css_pkg::css_op_t             skip_op,
  input  wire logic [1:0]                   skip_count,
  input  wire logic [1:0]                   accumulator_select,
  input  wire logic [4:0]                   bit_sel,
  input  wire logic [3:0][ACC_W-1:0]        accumulators,
  input  wire logic                         carry_in,
  input  wire logic                         overflow_in,
  input  wire logic                         sign_in,
  input  wire logic                         nonzero_in,
  input  wire logic [PC_W-1:0]              program_counter,
  input  wire logic [2:0]                   next_len,
  input  wire logic [3:0]                   next_cycles,
  output logic                              skip_ready,
  output logic                              fetch_req,
  output logic [PC_W-1:0]                   fetch_addr,
  output logic                              pc_load,
  output logic [PC_W-1:0]                   pc_next,
  output logic                              carry_out,
  output logic                              overflow_out,
  output logic                              sign_out,
  output logic                              nonzero_out,
  output logic                              busy
);
  typedef enum logic [1:0] {CSS_IDLE, CSS_SCAN, CSS_WAIT, CSS_DONE} css_state_t;

  typedef struct packed {
    css_state_t       state;
    logic [PC_W-1:0]  scan_pc;
    logic [1:0]       left;
    logic [3:0]       wait_cnt;
    logic             pc_load;
    logic [PC_W-1:0]  pc_next;
  } css_regs_t;

  css_regs_t r_q;
  css_regs_t r_d;
  logic      taken;

  if (PC_W < 4 || PC_W > 32 || ACC_W != CSS_ACC_W)
  begin : g_width_check
    $error("css_skip_seq: unsupported width");
  end

  function automatic logic [PC_W-1:0] css_pc_add(input logic [PC_W-1:0] pc,
                                                 input logic [2:0] len);
    css_pc_add = pc + PC_W'(len);
  endfunction : css_pc_add

  css_cond_eval #(
    .ACC_W (ACC_W)
  ) u_cond (
    .op                 (skip_op),
    .accumulators       (accumulators),
    .accumulator_select (accumulator_select),
    .bit_sel            (bit_sel),
    .carry              (carry_in),
    .overflow           (overflow_in),
    .sign               (sign_in),
    .nonzero            (nonzero_in),
    .taken              (taken)
  );

  always_comb
  begin
    r_d         = r_q;
    r_d.pc_load = 1'b0;
    unique case (r_q.state)
      CSS_IDLE:
        if (skip_valid)
        begin
          if (taken && skip_count != CSS_CNT_RST)
          begin
            r_d.scan_pc = css_pc_add(program_counter, CSS_SKIP_OP_LEN);
            r_d.left    = skip_count;
            r_d.state   = CSS_SCAN;
          end
          else
          begin
            r_d.pc_load = 1'b1;
            r_d.pc_next = css_pc_add(program_counter, CSS_SKIP_OP_LEN);
          end
        end
      CSS_SCAN:
      begin
        // step over one skipped instruction, burning its cycles
        r_d.scan_pc  = css_pc_add(r_q.scan_pc, next_len);
        r_d.left     = r_q.left - 2'h1;
        r_d.wait_cnt = (next_cycles > 4'h1) ? next_cycles - 4'h1 : 4'h0;
        r_d.state    = (r_d.wait_cnt != 4'h0) ? CSS_WAIT
                     : ((r_d.left == 2'h0) ? CSS_DONE : CSS_SCAN);
      end
      CSS_WAIT:
      begin
        r_d.wait_cnt = r_q.wait_cnt - 4'h1;
        if (r_d.wait_cnt == 4'h0)
          r_d.state = (r_q.left == 2'h0) ? CSS_DONE : CSS_SCAN;
      end
      CSS_DONE:
      begin
        r_d.pc_load = 1'b1;
        r_d.pc_next = r_q.scan_pc;
        r_d.state   = CSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      r_q.state    <= CSS_IDLE;
      r_q.scan_pc  <= PC_W'(CSS_PC_RST);
      r_q.left     <= CSS_CNT_RST;
      r_q.wait_cnt <= 4'h0;
      r_q.pc_load  <= 1'b0;
      r_q.pc_next  <= PC_W'(CSS_PC_RST);
    end
    else if (clk_en)
      r_q <= r_d;
  end

  assign skip_ready   = (r_q.state == CSS_IDLE);
  assign busy         = (r_q.state != CSS_IDLE);
  assign fetch_req    = (r_q.state == CSS_SCAN);
  assign fetch_addr   = r_q.scan_pc;
  assign pc_load      = r_q.pc_load;
  assign pc_next      = r_q.pc_next;
  // flags pass straight through untouched
  assign carry_out    = carry_in;
  assign overflow_out = overflow_in;
  assign sign_out     = sign_in;
  assign nonzero_out  = nonzero_in;

  property p_not_taken;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && skip_ready && skip_valid && !taken)
      |=> pc_load && pc_next == $past(program_counter) + PC_W'(1);
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("false skip pc wrong");

  property p_taken_scans;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && skip_ready && skip_valid && taken && skip_count != 2'h0)
      |=> fetch_req && !pc_load;
  endproperty
  a_taken_scans: assert property (p_taken_scans) else $error("taken skip not scanning");

  sequence s_done;
    r_q.state == CSS_DONE && clk_en;
  endsequence
  property p_done_loads;
    @(posedge clk) disable iff (sys_rst)
      s_done |=> pc_load && pc_next == $past(r_q.scan_pc);
  endproperty
  a_done_loads: assert property (p_done_loads) else $error("skip end pc wrong");

  property p_scan_step;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && fetch_req) |=> r_q.scan_pc == $past(fetch_addr) + PC_W'($past(next_len));
  endproperty
  a_scan_step: assert property (p_scan_step) else $error("scan step wrong");

  property p_flags;
    @(posedge clk) disable iff (sys_rst)
      busy |-> carry_out == carry_in && overflow_out == overflow_in
               && sign_out == sign_in && nonzero_out == nonzero_in;
  endproperty
  a_flags: assert property (p_flags) else $error("flag changed");

  property p_one_cycle;
    @(posedge clk) disable iff (sys_rst)
      (clk_en && skip_ready && skip_valid && !taken) |=> skip_ready;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("false skip not one cycle");

  property p_bit_low;
    @(posedge clk) disable iff (sys_rst)
      (skip_op == CSS_OP_BIT_LOW)
      |-> taken == !accumulators[accumulator_select][bit_sel];
  endproperty
  a_bit_low: assert property (p_bit_low) else $error("bit low wrong");

  property p_bit_high;
    @(posedge clk) disable iff (sys_rst)
      (skip_op == CSS_OP_BIT_HIGH)
      |-> taken == accumulators[accumulator_select][bit_sel];
  endproperty
  a_bit_high: assert property (p_bit_high) else $error("bit high wrong");

  property p_carry;
    @(posedge clk) disable iff (sys_rst)
      (skip_op == CSS_OP_CARRY || skip_op == CSS_OP_NO_CARRY)
      |-> taken == (carry_in ^ (skip_op == CSS_OP_NO_CARRY));
  endproperty
  a_carry: assert property (p_carry) else $error("carry cond wrong");

  property p_zero;
    @(posedge clk) disable iff (sys_rst)
      (skip_op == CSS_OP_ZERO) |-> taken == !nonzero_in;
  endproperty
  a_zero: assert property (p_zero) else $error("zero cond wrong");

  property p_sign;
    @(posedge clk) disable iff (sys_rst)
      (skip_op == CSS_OP_NEGATIVE) |-> taken == sign_in;
  endproperty
  a_sign: assert property (p_sign) else $error("sign cond wrong");

  property p_ovr;
    @(posedge clk) disable iff (sys_rst)
      (skip_op == CSS_OP_OVERFLOW) |-> taken == overflow_in;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overflow cond wrong");
endmodule : css_skip_seq

//--- css_pkg.sv
package css_pkg;
  localparam int unsigned CSS_PC_W        = 16;
  localparam int unsigned CSS_ACC_W       = 24;
  localparam int unsigned CSS_BIT_SEL_W   = 5;
  localparam int unsigned CSS_CNT_W       = 2;
  localparam int unsigned CSS_LEN_W       = 3;
  localparam int unsigned CSS_OP_W        = 4;
  localparam logic [2:0]  CSS_SKIP_OP_LEN = 3'h1;
  localparam logic [15:0] CSS_PC_RST      = 16'h0000;
  localparam logic [1:0]  CSS_CNT_RST     = 2'h0;
  localparam logic [4:0]  CSS_BIT_MAX     = 5'h17;
  localparam int unsigned CSS_EXEC_CYCLES = 1;

  typedef enum logic [3:0] {
    CSS_OP_ALWAYS,
    CSS_OP_BIT_LOW,
    CSS_OP_BIT_HIGH,
    CSS_OP_NO_CARRY,
    CSS_OP_CARRY,
    CSS_OP_ZERO,
    CSS_OP_NONZERO,
    CSS_OP_NEGATIVE,
    CSS_OP_POSITIVE,
    CSS_OP_NO_OVERFLOW,
    CSS_OP_OVERFLOW
  } css_op_t;
endpackage : css_pkg

//--- css_cond_eval.sv
`timescale 1ns/1ps
module css_cond_eval
  import css_pkg::*;
#(
  parameter int unsigned ACC_W = 24
) (
  input  wire css_pkg::css_op_t         op,
  input  wire logic [3:0][ACC_W-1:0]    accumulators,
  input  wire logic [1:0]               accumulator_select,
  input  wire logic [4:0]               bit_sel,
  input  wire logic                     carry,
  input  wire logic                     overflow,
  input  wire logic                     sign,
  input  wire logic                     nonzero,
  output logic                          taken
);
  logic tested_bit;

  always_comb
  begin
    tested_bit = accumulators[accumulator_select][bit_sel];
    unique case (op)
      CSS_OP_ALWAYS:      taken = 1'b1;
      CSS_OP_BIT_LOW:     taken = !tested_bit;
      CSS_OP_BIT_HIGH:    taken = tested_bit;
      CSS_OP_NO_CARRY:    taken = !carry;
      CSS_OP_CARRY:       taken = carry;
      CSS_OP_ZERO:        taken = !nonzero;
      CSS_OP_NONZERO:     taken = nonzero;
      CSS_OP_NEGATIVE:    taken = sign;
      CSS_OP_POSITIVE:    taken = !sign;
      CSS_OP_NO_OVERFLOW: taken = !overflow;
      CSS_OP_OVERFLOW:    taken = overflow;
      default:            taken = 1'b0;
    endcase
  end
endmodule : css_cond_eval

//--- tb_conditional_skip_sequencer.sv
`timescale 1ns/1ps
module tb_conditional_skip_sequencer;
  import css_pkg::*;
  logic             clk                = 1'b0;
  logic             sys_rst            = 1'b1;
  logic             clk_en             = 1'b1;
  logic             skip_valid         = 1'b0;
  css_op_t          skip_op            = CSS_OP_ALWAYS;
  logic [1:0]       skip_count         = 2'h1;
  logic [1:0]       accumulator_select = 2'h0;
  logic [4:0]       bit_sel            = 5'h00;
  logic [3:0][23:0] accumulators       = {24'hA5F00F, 24'h800001, 24'h5A3C96, 24'h7FFFFE};
  logic             carry_in           = 1'b0;
  logic             overflow_in        = 1'b0;
  logic             sign_in            = 1'b0;
  logic             nonzero_in         = 1'b0;
  logic [15:0]      program_counter    = 16'h0010;
  logic [2:0]       next_len;
  logic [3:0]       next_cycles;
  logic             skip_ready, fetch_req, pc_load, busy;
  logic [15:0]      fetch_addr, pc_next;
  logic             carry_out, overflow_out, sign_out, nonzero_out;
  logic [2:0]       len_mem [16];
  logic [3:0]       cyc_mem [16];
  int               bad_count          = 0;
  int               comparisons        = 0;

  always #50 clk = ~clk;
  // instruction memory lookup, combinational as the scan expects
  assign next_len    = len_mem[fetch_addr[3:0]];
  assign next_cycles = cyc_mem[fetch_addr[3:0]];

  css_skip_seq #(.PC_W(16), .ACC_W(24)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .skip_valid(skip_valid),
    .skip_op(skip_op), .skip_count(skip_count), .accumulator_select(accumulator_select),
    .bit_sel(bit_sel), .accumulators(accumulators), .carry_in(carry_in),
    .overflow_in(overflow_in), .sign_in(sign_in), .nonzero_in(nonzero_in),
    .program_counter(program_counter), .next_len(next_len), .next_cycles(next_cycles),
    .skip_ready(skip_ready), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .pc_load(pc_load), .pc_next(pc_next), .carry_out(carry_out),
    .overflow_out(overflow_out), .sign_out(sign_out), .nonzero_out(nonzero_out), .busy(busy));

  task automatic end_of_test;
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      bad_count++;
    end
  endtask : check

  function automatic logic want(input css_op_t op);
    case (op)
      CSS_OP_ALWAYS:      return 1'b1;
      CSS_OP_BIT_LOW:     return ~accumulators[accumulator_select][bit_sel];
      CSS_OP_BIT_HIGH:    return accumulators[accumulator_select][bit_sel];
      CSS_OP_NO_CARRY:    return ~carry_in;
      CSS_OP_CARRY:       return carry_in;
      CSS_OP_ZERO:        return ~nonzero_in;
      CSS_OP_NONZERO:     return nonzero_in;
      CSS_OP_NEGATIVE:    return sign_in;
      CSS_OP_POSITIVE:    return ~sign_in;
      CSS_OP_NO_OVERFLOW: return ~overflow_in;
      CSS_OP_OVERFLOW:    return overflow_in;
      default:            return 1'b0;
    endcase
  endfunction : want

  // issue one skip at a falling edge and judge target address and duration
  task automatic run_skip(input css_op_t op, input logic [1:0] cnt);
    logic        take;
    logic [15:0] exp_pc;
    int          exp_cyc;
    int          n;
    take    = want(op) && (cnt != 2'h0);
    exp_pc  = program_counter + 16'h0001;
    exp_cyc = 1;
    if (take)
    begin
      for (int k = 0; k < int'(cnt); k++)
      begin
        exp_cyc += (cyc_mem[exp_pc[3:0]] > 4'h1) ? int'(cyc_mem[exp_pc[3:0]]) : 1;
        exp_pc  += {13'h0000, len_mem[exp_pc[3:0]]};
      end
      exp_cyc += 1;
    end
    check({31'h0, skip_ready}, 32'h1);
    skip_op    = op;
    skip_count = cnt;
    skip_valid = 1'b1;
    @(negedge clk);
    skip_valid = 1'b0;
    check({30'h0, busy, fetch_req}, {30'h0, take, take});
    if (take)
      check({16'h0000, fetch_addr}, {16'h0000, program_counter + 16'h0001});
    n = 1;
    while (pc_load !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (pc_load !== 1'b1)
    begin
      bad_count++;
      end_of_test();
    end
    check(n, exp_cyc);
    check({16'h0000, pc_next}, {16'h0000, exp_pc});
    check({carry_out, overflow_out, sign_out, nonzero_out},
          {carry_in, overflow_in, sign_in, nonzero_in});
    program_counter = program_counter + 16'h0005;
    // let the load pulse end before the next request or freeze
    @(negedge clk);
  endtask : run_skip

  // every kind of skip against every flag pattern, a walking bit index plus the top bit, and count from 1 to 3
  task automatic t_all_ops;
    for (int o = 0; o < 11; o++)
    begin
      for (int f = 0; f < 16; f++)
      begin
        {carry_in, overflow_in, sign_in, nonzero_in} = 4'(f);
        accumulator_select = 2'(f + o);
        bit_sel            = (f == 15) ? 5'h17 : 5'((f + o) % 24);
        run_skip(css_op_t'(o), 2'(f % 3 + 1));
      end
    end
  endtask : t_all_ops

  // a zero count behaves like a false condition
  task automatic t_count_zero;
    run_skip(CSS_OP_ALWAYS, 2'h0);
  endtask : t_count_zero

  // requests while the clock enable is low must be ignored
  task automatic t_clk_en_hold;
    clk_en     = 1'b0;
    skip_valid = 1'b1;
    repeat (4)
    begin
      @(negedge clk);
      check({pc_load, busy}, 32'h0);
    end
    skip_valid = 1'b0;
    clk_en     = 1'b1;
    @(negedge clk);
    check({pc_load, busy}, 32'h0);
  endtask : t_clk_en_hold

  initial
  begin
    for (int i = 0; i < 16; i++)
    begin
      len_mem[i] = 3'(i % 4 + 1);
      cyc_mem[i] = 4'(i % 5);
    end
    repeat (6) @(posedge clk);
    @(negedge clk);
    check({pc_load, skip_ready, fetch_req}, 32'h2);
    check({16'h0000, pc_next}, 32'h0);
    sys_rst = 1'b0;
    t_all_ops();
    t_count_zero();
    t_clk_en_hold();
    run_skip(CSS_OP_ALWAYS, 2'h3);
    end_of_test();
  end
endmodule : tb_conditional_skip_sequencer
